//--- core/dpga_pin.sv
// Purpose: one bidirectional pin with an alternate function
// Assumes: pin input is synchronous to the system clock
// Notes:   output enable is active low; pin output is zero when not driven
`timescale 1ns/100ps
module dpga_pin (
	input  wire logic latchBit,
	input  wire logic dirBit,
	input  wire logic padIn,
	input  wire logic altTaken,
	input  wire logic altDrive,
	input  wire logic altOut,
	input  wire logic altReadsZero,
	output      logic padOut,
	output      logic padOeN,
	output      logic readBit
);
	// ==========================================================
	// driver
	logic driveOn;
	logic driveVal;

	// taken pins ignore the direction bit
	assign driveOn  = altTaken ? altDrive : dirBit;
	assign driveVal = altTaken ? altOut : latchBit;
	assign padOeN   = ~driveOn;
	// gated so an unwritten latch never shows as unknown on a floating pin
	assign padOut   = driveOn & driveVal;

	// ==========================================================
	// read path
	logic inputView;

	// latch never reaches the read path of an input pin
	assign inputView = (altTaken & altReadsZero) ? 1'b0 : padIn;
	assign readBit   = dirBit ? latchBit : inputView;
endmodule

//--- core/dpga_pkg.sv
// Purpose: constants shared by the dual port gpio with alternate functions
// Assumes: 32-bit classic wishbone, byte address = 4 x register index
// Notes:   register indices, field positions and pin positions live here
//
// Summary of operation
// - a direction bit of one drives the latch onto the pin, zero floats it.
// - reset clears every direction bit of both ports so all pins are inputs.
// - reading port d data at index 03 gives latch where output, pin where input, zero on taken input pins.
// - a latch write always lands and never changes what an input pin reads.
// - port d bits 6..0 are converter channels 14..8 picked by channel select.
// - a converter pin reads zero when input and the latch when output.
// - port d bits 6 and 4 feed the timer a and b external clocks when chosen.
// - on timer clock pins direction is ignored but picks latch or zero on read.
// - port e bit 7 is spi clock, input as slave, output as master, if enabled.
// - port e bits 6 and 5 are spi mosi and miso while the spi is enabled.
// - port e bit 4 is spi slave select unless disabled or master without fault.
// - port e bits 3 and 2 are timer a channels 1 and 0 when their select is set.
// - port e bits 1 and 0 are serial receive and transmit while serial enabled.
// - on taken port e pins direction is ignored but picks latch or pin on read.
// - reading port e data at index 08 gives latch where output, pin where input.
package dpga_pkg;
	// ==========================================================
	// register indices
	localparam logic [5:0] IDX_LATCH_D = 6'h03;
	localparam logic [5:0] IDX_LATCH_E = 6'h08;
	localparam logic [5:0] IDX_DIR_D   = 6'h07;
	localparam logic [5:0] IDX_DIR_E   = 6'h0C;
	localparam logic [5:0] IDX_CFG_D   = 6'h10;
	localparam logic [5:0] IDX_CFG_E   = 6'h11;
	localparam logic [5:0] IDX_TAKEN   = 6'h12;

	// ==========================================================
	// reset values
	localparam logic [7:0]  DIR_RST   = 8'h00;
	localparam logic [10:0] CFG_D_RST = 11'h000;
	localparam logic [7:0]  CFG_E_RST = 8'h00;

	// ==========================================================
	// port d configuration fields
	localparam int CONV_LSB = 0;
	localparam int CONV_W   = 5;
	localparam int PSA_LSB  = 5;
	localparam int PSB_LSB  = 8;
	localparam int PS_W     = 3;
	localparam logic [4:0] CONV_FIRST  = 5'h08;
	localparam logic [2:0] PS_EXT_CLK  = 3'h7;
	localparam int CONV_PINS = 7;

	// ==========================================================
	// port e configuration fields
	localparam int SPI_EN_BIT   = 0;
	localparam int SPI_MSTR_BIT = 1;
	localparam int MODF_BIT     = 2;
	localparam int SER_EN_BIT   = 3;
	localparam int ELS0_LSB     = 4;
	localparam int ELS1_LSB     = 6;
	localparam int ELS_W        = 2;
	localparam logic [1:0] ELS_OFF = 2'h0;

	// ==========================================================
	// pin positions
	localparam int D_TIMER_A_EXT_CLOCK = 6;
	localparam int D_TIMER_B_EXT_CLOCK = 4;
	localparam int E_SCK   = 7;
	localparam int E_MOSI  = 6;
	localparam int E_MISO  = 5;
	localparam int E_SS    = 4;
	localparam int E_TCH1  = 3;
	localparam int E_TCH0  = 2;
	localparam int E_RX    = 1;
	localparam int E_TX    = 0;
endpackage

//--- core/dpga_top.sv
// Purpose: ports d and e with latches, directions and pin sharing
// Assumes: classic wishbone slave, one wait state, data in the low two lanes
// Notes:   peripheral selects are mirrored in two local config registers
`timescale 1ns/100ps
module dpga_top
	import dpga_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        srst,
	input  wire logic        wbCyc,
	input  wire logic        wbStb,
	input  wire logic        wbWe,
	input  wire logic [7:0]  wbAdr,
	input  wire logic [3:0]  wbSel,
	input  wire logic [31:0] wbDatI,
	output      logic [31:0] wbDatO,
	output      logic        wbAck,
	input  wire logic [7:0]  padDIn,
	output      logic [7:0]  padDOut,
	output      logic [7:0]  padDOeN,
	input  wire logic [7:0]  padEIn,
	output      logic [7:0]  padEOut,
	output      logic [7:0]  padEOeN,
	output      logic [6:0]  converterChannelPin,
	output      logic        converterSelected,
	output      logic        timerAExtClock,
	output      logic        timerBExtClock,
	output      logic        spiEnable,
	output      logic        spiMaster,
	output      logic        spiModeFaultEnable,
	output      logic        spiClockIn,
	input  wire logic        spiClockOut,
	output      logic        spiMosiIn,
	input  wire logic        spiMosiOut,
	output      logic        spiMisoIn,
	input  wire logic        spiMisoOut,
	output      logic        spiSlaveSelIn,
	output      logic [1:0]  timerAChIn,
	input  wire logic [1:0]  timerAChOut,
	input  wire logic [1:0]  timerAChDrive,
	output      logic [1:0]  timerAChActive,
	output      logic        serialEnable,
	output      logic        serialRxIn,
	input  wire logic        serialTxOut
);
	// ==========================================================
	// registers
	logic [7:0]  latchD_ff;
	logic [7:0]  latchE_ff;
	logic [7:0]  dirD_ff;
	logic [7:0]  dirE_ff;
	logic [10:0] cfgD_ff;
	logic [7:0]  cfgE_ff;
	logic        ack_ff;
	logic [31:0] rdat_ff;

	// ==========================================================
	// bus decode
	logic [5:0]  adrIdx;
	logic        busReq;
	logic        wrStrobe;
	logic        rdStrobe;
	logic        lane0;
	logic        lane1;
	logic        hitLatchD;
	logic        hitLatchE;
	logic        hitDirD;
	logic        hitDirE;
	logic        hitCfgD;
	logic        hitCfgE;
	logic        hitTaken;

	assign adrIdx    = wbAdr[7:2];
	// one transfer per request: the ack cycle itself is not a new request
	assign busReq    = wbCyc & wbStb & ~ack_ff;
	assign wrStrobe  = busReq & wbWe;
	assign rdStrobe  = busReq & ~wbWe;
	assign lane0     = wbSel[0];
	assign lane1     = wbSel[1];
	assign hitLatchD = (adrIdx == IDX_LATCH_D);
	assign hitLatchE = (adrIdx == IDX_LATCH_E);
	assign hitDirD   = (adrIdx == IDX_DIR_D);
	assign hitDirE   = (adrIdx == IDX_DIR_E);
	assign hitCfgD   = (adrIdx == IDX_CFG_D);
	assign hitCfgE   = (adrIdx == IDX_CFG_E);
	assign hitTaken  = (adrIdx == IDX_TAKEN);

	// ==========================================================
	// next values
	logic [7:0]  nxt_latchD;
	logic [7:0]  nxt_latchE;
	logic [7:0]  nxt_dirD;
	logic [7:0]  nxt_dirE;
	logic [10:0] nxt_cfgD;
	logic [7:0]  nxt_cfgE;
	logic        wrLow;
	logic        wrHigh;

	assign wrLow  = wrStrobe & lane0;
	assign wrHigh = wrStrobe & lane1;

	// a latch write lands whatever the direction bit says
	assign nxt_latchD = (wrLow & hitLatchD) ? wbDatI[7:0] : latchD_ff;
	assign nxt_latchE = (wrLow & hitLatchE) ? wbDatI[7:0] : latchE_ff;
	assign nxt_dirD   = (wrLow & hitDirD) ? wbDatI[7:0] : dirD_ff;
	assign nxt_dirE   = (wrLow & hitDirE) ? wbDatI[7:0] : dirE_ff;
	assign nxt_cfgE   = (wrLow & hitCfgE) ? wbDatI[7:0] : cfgE_ff;
	assign nxt_cfgD[7:0]  = (wrLow & hitCfgD) ? wbDatI[7:0] : cfgD_ff[7:0];
	assign nxt_cfgD[10:8] = (wrHigh & hitCfgD) ? wbDatI[10:8] :
		cfgD_ff[10:8];

	// ==========================================================
	// latches carry no reset: contents survive a reset
	always_ff @(posedge clock) begin
		latchD_ff <= nxt_latchD;
		latchE_ff <= nxt_latchE;
	end

	// ==========================================================
	// direction
	always_ff @(posedge clock) begin
		if (srst) begin
			dirD_ff <= DIR_RST;
			dirE_ff <= DIR_RST;
		end else begin
			dirD_ff <= nxt_dirD;
			dirE_ff <= nxt_dirE;
		end
	end

	// ==========================================================
	// configuration mirrors of the peripheral selects
	always_ff @(posedge clock) begin
		if (srst) begin
			cfgD_ff <= CFG_D_RST;
			cfgE_ff <= CFG_E_RST;
		end else begin
			cfgD_ff <= nxt_cfgD;
			cfgE_ff <= nxt_cfgE;
		end
	end

	// ==========================================================
	// configuration fields
	logic [4:0] convSel;
	logic [2:0] psA;
	logic [2:0] psB;
	logic       spiEn;
	logic       spiMstr;
	logic       mode_fault_enable;
	logic       serEn;
	logic [1:0] els0;
	logic [1:0] els1;

	assign convSel = cfgD_ff[CONV_LSB +: CONV_W];
	assign psA     = cfgD_ff[PSA_LSB +: PS_W];
	assign psB     = cfgD_ff[PSB_LSB +: PS_W];
	assign spiEn   = cfgE_ff[SPI_EN_BIT];
	assign spiMstr = cfgE_ff[SPI_MSTR_BIT];
	assign mode_fault_enable  = cfgE_ff[MODF_BIT];
	assign serEn   = cfgE_ff[SER_EN_BIT];
	assign els0    = cfgE_ff[ELS0_LSB +: ELS_W];
	assign els1    = cfgE_ff[ELS1_LSB +: ELS_W];

	assign spiEnable          = spiEn;
	assign spiMaster          = spiMstr;
	assign spiModeFaultEnable = mode_fault_enable;
	assign serialEnable       = serEn;

	// ==========================================================
	// port d ownership
	logic [7:0] convTakeD;
	logic [7:0] timerTakeD;
	logic [7:0] takenD;
	logic       extClkA;
	logic       extClkB;

	genvar gi;
	generate
		for (gi = 0; gi < CONV_PINS; gi++) begin : gConv
			// channel 8 sits on bit 0, channel 14 on bit 6
			assign convTakeD[gi] = (convSel == CONV_FIRST + 5'(gi));
		end
	endgenerate
	assign convTakeD[7] = 1'b0;

	assign extClkA = (psA == PS_EXT_CLK);
	assign extClkB = (psB == PS_EXT_CLK);
	always_comb begin
		timerTakeD          = 8'h00;
		timerTakeD[D_TIMER_A_EXT_CLOCK] = extClkA;
		timerTakeD[D_TIMER_B_EXT_CLOCK] = extClkB;
	end
	assign takenD = convTakeD | timerTakeD;
	assign converterSelected = |convTakeD;

	// ==========================================================
	// port e ownership and direction when taken
	logic [7:0] takenE;
	logic [7:0] driveE;
	logic [7:0] altOutE;
	logic       ssTaken;
	logic [1:0] chActive;

	// a master that ignores mode faults leaves slave select to the port
	assign ssTaken  = spiEn & ~(spiMstr & ~mode_fault_enable);
	assign chActive = {(els1 != ELS_OFF), (els0 != ELS_OFF)};
	assign timerAChActive = chActive;

	always_comb begin
		takenE          = 8'h00;
		takenE[E_SCK]   = spiEn;
		takenE[E_MOSI]  = spiEn;
		takenE[E_MISO]  = spiEn;
		takenE[E_SS]    = ssTaken;
		takenE[E_TCH1]  = chActive[1];
		takenE[E_TCH0]  = chActive[0];
		takenE[E_RX]    = serEn;
		takenE[E_TX]    = serEn;
	end

	always_comb begin
		driveE          = 8'h00;
		driveE[E_SCK]   = spiMstr;
		driveE[E_MOSI]  = spiMstr;
		driveE[E_MISO]  = ~spiMstr;
		driveE[E_SS]    = 1'b0;
		driveE[E_TCH1]  = timerAChDrive[1];
		driveE[E_TCH0]  = timerAChDrive[0];
		driveE[E_RX]    = 1'b0;
		driveE[E_TX]    = 1'b1;
	end

	always_comb begin
		altOutE         = 8'h00;
		altOutE[E_SCK]  = spiClockOut;
		altOutE[E_MOSI] = spiMosiOut;
		altOutE[E_MISO] = spiMisoOut;
		altOutE[E_TCH1] = timerAChOut[1];
		altOutE[E_TCH0] = timerAChOut[0];
		altOutE[E_TX]   = serialTxOut;
	end

	// ==========================================================
	// pin cells
	logic [7:0] readD;
	logic [7:0] readE;

	generate
		for (gi = 0; gi < 8; gi++) begin : gPins
			// analog and clock pins are inputs only: driver stays off
			dpga_pin uPinD (
				.latchBit     (latchD_ff[gi]),
				.dirBit       (dirD_ff[gi]),
				.padIn        (padDIn[gi]),
				.altTaken     (takenD[gi]),
				.altDrive     (1'b0),
				.altOut       (1'b0),
				.altReadsZero (1'b1),
				.padOut       (padDOut[gi]),
				.padOeN       (padDOeN[gi]),
				.readBit      (readD[gi])
			);
		end
	endgenerate

	generate
		for (gi = 0; gi < 8; gi++) begin : gPinsE
			dpga_pin uPinE (
				.latchBit     (latchE_ff[gi]),
				.dirBit       (dirE_ff[gi]),
				.padIn        (padEIn[gi]),
				.altTaken     (takenE[gi]),
				.altDrive     (driveE[gi]),
				.altOut       (altOutE[gi]),
				.altReadsZero (1'b0),
				.padOut       (padEOut[gi]),
				.padOeN       (padEOeN[gi]),
				.readBit      (readE[gi])
			);
		end
	endgenerate

	// ==========================================================
	// pin levels towards the peripherals
	// converter, spi and timer channel inputs see the pin whether or not owned; ext clocks, slave select and rx are gated here
	assign converterChannelPin = padDIn[CONV_PINS-1:0];
	assign timerAExtClock = extClkA & padDIn[D_TIMER_A_EXT_CLOCK];
	assign timerBExtClock = extClkB & padDIn[D_TIMER_B_EXT_CLOCK];
	assign spiClockIn     = padEIn[E_SCK];
	assign spiMosiIn      = padEIn[E_MOSI];
	assign spiMisoIn      = padEIn[E_MISO];
	// an unowned slave select reads as deselected
	assign spiSlaveSelIn  = ssTaken ? padEIn[E_SS] : 1'b1;
	assign timerAChIn     = {padEIn[E_TCH1], padEIn[E_TCH0]};
	// idle line level is high while the serial port is off
	assign serialRxIn     = serEn ? padEIn[E_RX] : 1'b1;

	// ==========================================================
	// read mux
	logic [31:0] rdMux;

	always_comb begin
		rdMux = 32'h0000_0000;
		if (hitLatchD) begin
			rdMux[7:0] = readD;
		end else if (hitLatchE) begin
			rdMux[7:0] = readE;
		end else if (hitDirD) begin
			rdMux[7:0] = dirD_ff;
		end else if (hitDirE) begin
			rdMux[7:0] = dirE_ff;
		end else if (hitCfgD) begin
			rdMux[10:0] = cfgD_ff;
		end else if (hitCfgE) begin
			rdMux[7:0] = cfgE_ff;
		end else if (hitTaken) begin
			rdMux[15:0] = {takenE, takenD};
		end
	end

	// ==========================================================
	// bus answer: one cycle after the request
	always_ff @(posedge clock) begin
		if (srst) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= busReq;
		end
	end

	// ==========================================================
	// read data: taken at the request edge, unmapped reads give zero
	always_ff @(posedge clock) begin
		if (srst) begin
			rdat_ff <= 32'h0000_0000;
		end else if (rdStrobe) begin
			rdat_ff <= rdMux;
		end
	end

	assign wbAck  = ack_ff;
	assign wbDatO = rdat_ff;
endmodule

//--- test/dpga_far_side.sv
// Purpose: pins and peripherals beyond dpga_top
// Assumes: undriven pins show the level the bench puts on them
// Notes:   bench moves extD and extE often so a float never looks held
`timescale 1ns/100ps
module dpga_far_side (
	input  wire logic [7:0] extD,
	input  wire logic [7:0] extE,
	input  wire logic [7:0] per,
	input  wire logic [7:0] padDOut,
	input  wire logic [7:0] padDOeN,
	input  wire logic [7:0] padEOut,
	input  wire logic [7:0] padEOeN,
	output      logic [7:0] padDIn,
	output      logic [7:0] padEIn,
	output      logic       spiClockOut,
	output      logic       spiMosiOut,
	output      logic       spiMisoOut,
	output      logic       serialTxOut,
	output      logic [1:0] timerAChOut,
	output      logic [1:0] timerAChDrive
);
	// ==========================================================
	// wire level: the driving party wins
	assign padDIn = (padDOut & ~padDOeN) | (extD & padDOeN);
	assign padEIn = (padEOut & ~padEOeN) | (extE & padEOeN);
	// peripheral outputs come straight from the bench pattern
	assign {spiClockOut, spiMosiOut, spiMisoOut, serialTxOut,
		timerAChOut, timerAChDrive} = per;
endmodule

//--- test/dpga_monitor.sv
// Purpose: port checks beside dpga_top
// Assumes: one clock, srst synchronous active high
// Notes:   pin relations are combinational, sampled at each edge
`timescale 1ns/100ps
module dpga_monitor (
	input wire logic        clock,
	input wire logic        srst,
	input wire logic        wbCyc,
	input wire logic        wbStb,
	input wire logic        wbWe,
	input wire logic        wbAck,
	input wire logic [31:0] wbDatO,
	input wire logic [7:0]  padDIn,
	input wire logic [7:0]  padDOeN,
	input wire logic [7:0]  padEIn,
	input wire logic [7:0]  padEOut,
	input wire logic [7:0]  padEOeN,
	input wire logic [6:0]  converterChannelPin,
	input wire logic        timerAExtClock,
	input wire logic        timerBExtClock,
	input wire logic        spiEnable,
	input wire logic        spiMaster,
	input wire logic        spiModeFaultEnable,
	input wire logic        spiClockIn,
	input wire logic        spiMosiIn,
	input wire logic        spiMisoIn,
	input wire logic        spiClockOut,
	input wire logic        spiMisoOut,
	input wire logic        spiSlaveSelIn,
	input wire logic [1:0]  timerAChActive,
	input wire logic [1:0]  timerAChIn,
	input wire logic [1:0]  timerAChDrive,
	input wire logic        serialEnable,
	input wire logic        serialRxIn,
	input wire logic        serialTxOut
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	// ==========================================================
	// bus handshake
	sequence reqS; wbCyc && wbStb && !wbAck; endsequence
	sequence ackS; wbAck ##1 !wbAck; endsequence
	a_ack_pulse: assert property (reqS |=> ackS)
		else $error("ack not one pulse after request");
	a_data_holds: assert property (
		!(wbCyc && wbStb && !wbAck && !wbWe) |=> $stable(wbDatO))
		else $error("read data moved");
	// ==========================================================
	// pins; reset check must run while srst is high
	a_reset_float: assert property (disable iff (1'b0)
		srst |=> padDOeN == 8'hFF && padEOeN == 8'hFF)
		else $error("pin driven after reset");
	a_clk_a_pin: assert property (timerAExtClock |->
		padDIn[6] && padDOeN[6]) else $error("clock a pin");
	a_clk_b_pin: assert property (timerBExtClock |->
		padDIn[4] && padDOeN[4]) else $error("clock b pin");
	a_conv_route: assert property (
		converterChannelPin == padDIn[6:0]) else $error("converter pins");
	a_serial_pins: assert property (serialEnable |->
		padEOeN[1] && serialRxIn == padEIn[1] && !padEOeN[0] &&
		padEOut[0] == serialTxOut) else $error("serial pins");
	a_sck_master: assert property (spiEnable && spiMaster |->
		!padEOeN[7] && padEOut[7] == spiClockOut)
		else $error("spi clock as master");
	a_miso_slave: assert property (spiEnable && !spiMaster |->
		padEOeN[7] && !padEOeN[5] && padEOut[5] == spiMisoOut)
		else $error("spi slave pins");
	a_ss_owned: assert property (spiEnable &&
		!(spiMaster && !spiModeFaultEnable) |-> padEOeN[4] &&
		spiSlaveSelIn == padEIn[4]) else $error("slave select");
	a_ch_drive: assert property (timerAChActive[0] |->
		padEOeN[2] != timerAChDrive[0]) else $error("timer channel drive");
	a_ch1_drive: assert property (timerAChActive[1] |->
		padEOeN[3] != timerAChDrive[1] && timerAChIn == padEIn[3:2])
		else $error("timer channel one drive");
	a_spi_inputs: assert property (spiEnable |->
		spiClockIn == padEIn[7] && spiMosiIn == padEIn[6] &&
		spiMisoIn == padEIn[5]) else $error("spi input levels");
endmodule
bind dpga_top dpga_monitor u_mon (.*);

//--- test/dpga_top_tb_top.sv
// Purpose: self-checking bench for dpga_top
// Assumes: one wait state bus, far side in dpga_far_side
// Notes:   read results are checked from a queue by a watcher
`timescale 1ns/100ps
module dpga_top_tb_top;
	import dpga_pkg::*;
	logic        clock = 1'b0, srst = 1'b1, wbCyc = 1'b0, wbStb = 1'b0;
	logic        wbWe = 1'b0;
	logic [7:0]  wbAdr = 8'h00, extD = 8'h00, extE = 8'h00, per = 8'h00;
	logic [3:0]  wbSel = 4'h0;
	logic [31:0] wbDatI = 32'h0, wbDatO;
	logic        wbAck, converterSelected, timerAExtClock, timerBExtClock;
	logic        spiEnable, spiMaster, spiModeFaultEnable, spiClockIn;
	logic        spiMosiIn, spiMisoIn, spiSlaveSelIn, serialEnable;
	logic        serialRxIn, spiClockOut, spiMosiOut, spiMisoOut;
	logic        serialTxOut;
	logic [7:0]  padDIn, padDOut, padDOeN, padEIn, padEOut, padEOeN;
	logic [6:0]  converterChannelPin;
	logic [1:0]  timerAChIn, timerAChOut, timerAChDrive, timerAChActive;
	logic [7:0]  L, M;
	logic [31:0] expQ[$];
	int          fail_count = 0, cmp_count = 0, seed = 64018;
	logic [10:0] cfgDs[14] = '{11'h000, 11'h008, 11'h009, 11'h00A,
		11'h00B, 11'h00C, 11'h00D, 11'h00E, 11'h00F, 11'h7E0, 11'h0E0,
		11'h700, 11'h7EC, 11'h010};
	logic [7:0]  cfgEs[12] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h08, 8'h10,
		8'h20, 8'h30, 8'h40, 8'h80, 8'hC0, 8'h0F};

	dpga_top u_dut (.*);
	dpga_far_side u_far (.*);
	always #50 clock = ~clock;

	// ==========================================================
	// compare, verdict, bus
	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic wb(input logic we, input logic [5:0] idx,
		input logic [31:0] d);
		@(posedge clock);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= {idx, 2'b00};
		wbDatI <= d;
		wbSel <= 4'hF;
		// no assumed latency: only the watchdog ends a hung wait
		do @(posedge clock); while (wbAck !== 1'b1);
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
	endtask
	task automatic wr(input logic [5:0] idx, input logic [31:0] d);
		wb(1'b1, idx, d);
	endtask
	task automatic rd(input logic [5:0] idx, input logic [31:0] e);
		expQ.push_back(e);
		wb(1'b0, idx, 32'h0);
	endtask
	// the read watcher takes the oldest note on each read ack
	always @(posedge clock) begin
		if (wbAck === 1'b1 && wbWe === 1'b0 && expQ.size() > 0)
			check(wbDatO, expQ.pop_front(), "read");
	end

	// ==========================================================
	// expectations: {taken, enables low, pad drive, read value}
	function automatic logic [31:0] dExp(input logic [10:0] c,
		input logic [7:0] m, input logic [7:0] l, input logic [7:0] x);
		logic [7:0] drv, z, pin;
		z = 8'h00;
		if (c[4:0] >= CONV_FIRST && c[4:0] < CONV_FIRST + 5'h07)
			z[c[4:0] - CONV_FIRST] = 1'b1;
		if (c[7:5] == PS_EXT_CLK) z[6] = 1'b1;
		if (c[10:8] == PS_EXT_CLK) z[4] = 1'b1;
		drv = m & ~z;
		pin = (l & drv) | (x & ~drv);
		return {z, ~drv, l & drv, (l & m) | (pin & ~m & ~z)};
	endfunction
	function automatic logic [31:0] eExp(input logic [7:0] c,
		input logic [7:0] m, input logic [7:0] l, input logic [7:0] x,
		input logic [7:0] p);
		logic [7:0] drv, o, pin, t;
		drv = m;
		o = l;
		t = 8'h00;
		if (c[0]) begin
			drv[7:5] = {c[1], c[1], !c[1]};
			o[7:5] = p[7:5];
			t[7:4] = {3'b111, !c[1] || c[2]};
			if (!c[1] || c[2]) drv[4] = 1'b0;
		end
		if (c[3]) begin
			drv[1:0] = 2'b01;
			o[0] = p[4];
			t[1:0] = 2'b11;
		end
		if (c[5:4] != ELS_OFF)
			{t[2], drv[2], o[2]} = {1'b1, p[0], p[2]};
		if (c[7:6] != ELS_OFF)
			{t[3], drv[3], o[3]} = {1'b1, p[1], p[3]};
		pin = (o & drv) | (x & ~drv);
		return {t, ~drv, o & drv, (l & m) | (pin & ~m)};
	endfunction

	// ==========================================================
	// one configuration; latch goes in before direction
	task automatic runPort(input logic isE, input logic [10:0] c);
		logic [31:0] e;
		L = 8'($random(seed));
		M = 8'($random(seed));
		extD <= 8'($random(seed));
		extE <= 8'($random(seed));
		per <= 8'($random(seed));
		wr(isE ? IDX_LATCH_E : IDX_LATCH_D, {24'h0, L});
		wr(isE ? IDX_CFG_E : IDX_CFG_D, {21'h0, c});
		wr(isE ? IDX_DIR_E : IDX_DIR_D, {24'h0, M});
		e = isE ? eExp(c[7:0], M, L, extE, per) : dExp(c, M, L, extD);
		check(isE ? padEOeN : padDOeN, e[23:16], "enables");
		check(isE ? padEOut : padDOut, e[15:8], "drive");
		if (!isE) check(converterSelected, c[4:0] >= 5'h08 &&
			c[4:0] <= 5'h0E, "converter");
		rd(isE ? IDX_LATCH_E : IDX_LATCH_D, {24'h0, e[7:0]});
		// the other port still holds a configuration that takes no pin
		rd(IDX_TAKEN, isE ? {16'h0, e[31:24], 8'h00}
			: {24'h0, e[31:24]});
	endtask

	initial begin
		repeat (10) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		check(padDOeN & padEOeN, 8'hFF, "reset enables");
		rd(IDX_DIR_D, 32'h0);
		rd(IDX_DIR_E, 32'h0);
		for (int k = 0; k < 28; k++) runPort(1'b0, cfgDs[k % 14]);
		for (int k = 0; k < 36; k++) runPort(1'b1, {3'h0, cfgEs[k % 12]});
		wr(IDX_LATCH_D, 32'h5A);
		wr(IDX_LATCH_E, 32'hC3);
		srst <= 1'b1;
		@(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		check(padDOeN & padEOeN, 8'hFF, "second reset");
		wr(IDX_DIR_D, 32'hFF);
		wr(IDX_DIR_E, 32'hFF);
		rd(IDX_LATCH_D, 32'h5A);
		rd(IDX_LATCH_E, 32'hC3);
		wr(6'h3F, 32'hFFFFFFFF);
		rd(6'h3F, 32'h0);
		@(posedge clock);
		report_and_stop();
	end
	// ample for about 330 bus cycles of three clocks each
	initial begin
		repeat (5000) @(posedge clock);
		fail_count++;
		report_and_stop();
	end
endmodule
